// >>> design/rci_pkg.sv
// Shared constants, types and register map of the reset-cause and init block
package rci_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned HZ_PER_KHZ     = 1000;
  localparam int unsigned POWERUP_DLY_MS = 72;
  // Least time, so round up to whole cycles
  localparam int unsigned POWERUP_DLY_CYC_DFLT =
    (POWERUP_DLY_MS * CLK_HZ + HZ_PER_KHZ - 1) / HZ_PER_KHZ;
  // Oscillator start count, one system clock per oscillator cycle
  localparam int unsigned OSC_START_TOSC = 1024;
  localparam int unsigned OSC_START_CYC  = OSC_START_TOSC;
  localparam int unsigned TMR_W          = 24;

  // ***************************************************************
  // Bus and widths
  // ***************************************************************
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 13;
  localparam int unsigned IRQ_W   = 24;
  localparam int unsigned EVT_W   = 4;
  localparam int unsigned ASYNC_W = 3;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [ADDR_W-1:0] ADDR_POWER_RESET_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET_FLAGS        = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS         = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_EVT_CLEAR          = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE         = 4'h4;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int unsigned BROWNOUT_FLAG_BIT  = 0;
  localparam int unsigned POWERON_FLAG_BIT   = 1;
  localparam int unsigned POWERDOWN_FLAG_BIT = 0;
  localparam int unsigned TIMEOUT_FLAG_BIT   = 1;
  localparam int unsigned STATE_FIELD_LSB    = 3;
  localparam logic [1:0]  PWR_STATUS_RST     = 2'h0;
  localparam int unsigned EVT_BROWNOUT       = 0;
  localparam int unsigned EVT_WATCHDOG       = 1;
  localparam int unsigned EVT_WAKE           = 2;
  localparam int unsigned EVT_MASTER_CLEAR   = 3;

  // Async input slots
  localparam int unsigned ASYNC_MASTER_CLEAR_PIN_N   = 0;
  localparam int unsigned ASYNC_BROWNOUT = 1;
  localparam int unsigned ASYNC_WATCHDOG = 2;

  // ***************************************************************
  // Program counter and register init values
  // ***************************************************************
  localparam logic [PC_W-1:0]   PC_RESET_VEC = 13'h000;
  localparam logic [PC_W-1:0]   PC_IRQ_VEC   = 13'h004;
  localparam logic [PC_W-1:0]   PC_STEP      = 13'h001;
  localparam logic [DATA_W-1:0] INIT_OPTION  = 8'hff;
  localparam logic [DATA_W-1:0] INIT_PORTDIR = 8'hff;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    OSC_CRYSTAL_LOWPOWER_MODE = 2'h0,
    OSC_CRYSTAL_STD_MODE      = 2'h1,
    OSC_CRYSTAL_FAST_MODE     = 2'h2,
    OSC_RC_MODE               = 2'h3
  } rci_osc_e;

  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_SLEEP = 5'h02,
    ST_HOLD  = 5'h04,
    ST_PDLY  = 5'h08,
    ST_OSC   = 5'h10
  } rci_state_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rci_bus_req_s;

  typedef struct packed {
    rci_osc_e osc_mode;
    logic     powerup_delay_enable_n;
    logic     brownout_detect_enable;
  } rci_cfg_s;

endpackage : rci_pkg

// >>> design/rci_delay_timer.sv
// Down-counter used for both the power-up delay and the oscillator start count
`timescale 1ns/1ps
`default_nettype none
module rci_delay_timer
  import rci_pkg::*;
(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  // Control
  input  wire logic             i_start,
  input  wire logic             i_abort,
  input  wire logic [TMR_W-1:0] i_count,
  // Status
  output logic                  o_busy,
  output logic                  o_done
);

  logic [TMR_W-1:0] cnt_reg;
  localparam logic [TMR_W-1:0] CNT_ONE = 24'h000001;

  // ***************************************************************
  // Counter: done pulses in the cycle after the last count
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        // Abort wins so a restart never overlaps a stale count
        o_busy <= 1'b0;
      end else if (i_start) begin
        cnt_reg <= i_count;
        o_busy  <= 1'b1;
      end else if (o_busy) begin
        if (cnt_reg == CNT_ONE) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        cnt_reg <= cnt_reg - CNT_ONE;
      end
    end
  end

endmodule // rci_delay_timer
`default_nettype wire

// >>> design/rci_top.sv
// Reset-cause recorder, start-up delay sequencer and reset init control
// What this block does
// - Status register: bit0 brown-out, bit1 power-on.
// - Brown-out reset clears brown-out flag; software sets.
// - Power-on clears power-on flag; others leave it.
// - Brown-out waits delay; wake waits oscillator only.
// - Power-on leaves timeout and powerdown both set.
// - Brown-out, watchdog reset, watchdog wake flag codes.
// - Master clear: running unchanged, sleeping timeout1 powerdown0.
// - Resets load zero; wake-ups continue at PC+1.
// - Interrupt wake with global enable loads vector.
// - Resets force init values; wake-ups keep registers.
// - Status reset patterns per reset type.
// - Interrupt wake needs a pending interrupt flag.
// - Brown-out detection forces power-up delay on.
// - Crystal modes: oscillator count 1024 follows delay, then release.
// - Watchdog time-out clears timeout flag in run, and in sleep unless the pin also falls.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rci_top
  import rci_pkg::*;
#(
  parameter int unsigned POWERUP_DLY_CYC = POWERUP_DLY_CYC_DFLT
)(
  // Clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_n,
  // Register bus
  input  wire rci_pkg::rci_bus_req_s i_bus,
  output logic [rci_pkg::DATA_W-1:0] o_rd_data,
  // Configuration
  input  wire rci_pkg::rci_cfg_s   i_cfg,
  // Pins and detectors, asynchronous
  input  wire logic                i_master_clear_pin_n,
  input  wire logic                i_brownout_det,
  input  wire logic                i_watchdog_timeout,
  // Core side
  input  wire logic                i_sleep_enter,
  input  wire logic [rci_pkg::PC_W-1:0]  i_pc,
  input  wire logic                i_global_irq_enable,
  input  wire logic [rci_pkg::IRQ_W-1:0] i_irq_flags,
  input  wire logic [rci_pkg::IRQ_W-1:0] i_irq_enables,
  // Outputs to core
  output logic                     o_core_reset,
  output logic                     o_init_strobe,
  output logic                     o_pc_load,
  output logic [rci_pkg::PC_W-1:0] o_pc_value,
  output logic                     o_timeout_flag,
  output logic                     o_powerdown_flag,
  output logic [rci_pkg::DATA_W-1:0] o_option_init,
  output logic [rci_pkg::DATA_W-1:0] o_portdir_init,
  // Interrupt
  output logic                     o_irq
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  localparam logic [TMR_W-1:0] PDLY_COUNT = TMR_W'(POWERUP_DLY_CYC);
  localparam logic [TMR_W-1:0] OSC_COUNT  = TMR_W'(OSC_START_CYC);

  logic [ASYNC_W-1:0] async_in;
  logic [ASYNC_W-1:0] sync1_reg;
  logic [ASYNC_W-1:0] sync2_reg;
  logic [ASYNC_W-1:0] sync3_reg;
  logic               master_clear_pin_n_s;
  logic               master_clear_pin_fall;
  logic               brownout_s;
  logic               watchdog_rise;
  logic               brownout_ev;
  logic               crystal;
  logic               irq_pending;

  rci_state_e         state_reg;
  logic               por_pending_reg;
  logic               pdly_req_reg;
  logic               tmr_start_reg;
  logic               tmr_abort_reg;
  logic [TMR_W-1:0]   tmr_count_reg;
  logic               tmr_busy;
  logic               tmr_done;

  logic [1:0]         pwr_status_reg;
  logic [EVT_W-1:0]   evt_status_reg;
  logic [EVT_W-1:0]   evt_enable_reg;
  logic [EVT_W-1:0]   evt_set;
  logic [EVT_W-1:0]   evt_clr;

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  assign async_in[ASYNC_MASTER_CLEAR_PIN_N]   = i_master_clear_pin_n;
  assign async_in[ASYNC_BROWNOUT] = i_brownout_det;
  assign async_in[ASYNC_WATCHDOG] = i_watchdog_timeout;

  // Two flops per pin, third only for edge detection off the second
  generate
    for (genvar g = 0; g < ASYNC_W; g++) begin : g_sync
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_reg[g] <= (g == ASYNC_MASTER_CLEAR_PIN_N);
          sync2_reg[g] <= (g == ASYNC_MASTER_CLEAR_PIN_N);
          sync3_reg[g] <= (g == ASYNC_MASTER_CLEAR_PIN_N);
        end else begin
          sync1_reg[g] <= async_in[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
        end
      end
    end
  endgenerate

  assign master_clear_pin_n_s      = sync2_reg[ASYNC_MASTER_CLEAR_PIN_N];
  assign master_clear_pin_fall     = sync3_reg[ASYNC_MASTER_CLEAR_PIN_N] & ~sync2_reg[ASYNC_MASTER_CLEAR_PIN_N];
  assign brownout_s    = sync2_reg[ASYNC_BROWNOUT];
  assign watchdog_rise = sync2_reg[ASYNC_WATCHDOG] & ~sync3_reg[ASYNC_WATCHDOG];

  // Detector output only counts while detection is enabled
  assign brownout_ev = brownout_s & i_cfg.brownout_detect_enable;
  assign crystal     = (i_cfg.osc_mode != OSC_RC_MODE);
  // Wake only on a real flag, so software can always find the source
  assign irq_pending = |(i_irq_flags & i_irq_enables);

  // ***************************************************************
  // Delay timer shared by power-up delay and oscillator start
  // ***************************************************************
  rci_delay_timer rci_delay_timer_inst (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (tmr_start_reg),
    .i_abort   (tmr_abort_reg),
    .i_count   (tmr_count_reg),
    .o_busy    (tmr_busy),
    .o_done    (tmr_done)
  );

  // ***************************************************************
  // Sequencer: reset causes, wake-ups and start-up delays
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Power-on: timeout and powerdown both set
      state_reg        <= ST_HOLD;
      por_pending_reg  <= 1'b1;
      pdly_req_reg     <= 1'b0;
      tmr_start_reg    <= 1'b0;
      tmr_abort_reg    <= 1'b0;
      tmr_count_reg    <= '0;
      o_timeout_flag   <= 1'b1;
      o_powerdown_flag <= 1'b1;
      o_pc_load        <= 1'b1;
      o_pc_value       <= PC_RESET_VEC;
      o_init_strobe    <= 1'b1;
    end else begin
      tmr_start_reg <= 1'b0;
      tmr_abort_reg <= 1'b0;
      o_pc_load     <= 1'b0;
      o_init_strobe <= 1'b0;
      if (brownout_ev && state_reg != ST_HOLD) begin
        // Brown-out in any state but hold restarts the whole delay chain
        state_reg        <= ST_HOLD;
        pdly_req_reg     <= 1'b1;
        tmr_abort_reg    <= 1'b1;
        o_timeout_flag   <= 1'b1;
        o_powerdown_flag <= 1'b1;
        o_pc_load        <= 1'b1;
        o_pc_value       <= PC_RESET_VEC;
        o_init_strobe    <= 1'b1;
      end else begin
        case (state_reg)
          ST_RUN: begin
            if (watchdog_rise) begin
              // Watchdog reset: no start-up delay
              o_timeout_flag   <= 1'b0;
              o_powerdown_flag <= 1'b1;
              o_pc_load        <= 1'b1;
              o_pc_value       <= PC_RESET_VEC;
              o_init_strobe    <= 1'b1;
            end else if (master_clear_pin_fall) begin
              // Flags keep their values while running
              o_pc_load     <= 1'b1;
              o_pc_value    <= PC_RESET_VEC;
              o_init_strobe <= 1'b1;
            end else if (i_sleep_enter) begin
              o_timeout_flag   <= 1'b1;
              o_powerdown_flag <= 1'b0;
              state_reg        <= ST_SLEEP;
            end
          end
          ST_SLEEP: begin
            if (master_clear_pin_fall) begin
              o_timeout_flag   <= 1'b1;
              o_powerdown_flag <= 1'b0;
              o_pc_load        <= 1'b1;
              o_pc_value       <= PC_RESET_VEC;
              o_init_strobe    <= 1'b1;
              state_reg        <= ST_RUN;
            end else if (watchdog_rise || irq_pending) begin
              // Wake-ups keep register contents, no init strobe
              o_timeout_flag   <= ~watchdog_rise;
              o_powerdown_flag <= 1'b0;
              o_pc_load        <= 1'b1;
              if (!watchdog_rise && i_global_irq_enable) begin
                o_pc_value <= PC_IRQ_VEC;
              end else begin
                o_pc_value <= i_pc + PC_STEP;
              end
              if (crystal) begin
                // Crystal needs restart time after sleep; RC does not
                tmr_start_reg <= 1'b1;
                tmr_count_reg <= OSC_COUNT;
                state_reg     <= ST_OSC;
              end else begin
                state_reg <= ST_RUN;
              end
            end
          end
          ST_HOLD: begin
            // Wait here until the supply is back above the trip level
            if (!brownout_ev) begin
              por_pending_reg <= 1'b0;
              if (pdly_req_reg || !i_cfg.powerup_delay_enable_n ||
                  i_cfg.brownout_detect_enable) begin
                tmr_start_reg <= 1'b1;
                tmr_count_reg <= PDLY_COUNT;
                state_reg     <= ST_PDLY;
              end else if (crystal) begin
                tmr_start_reg <= 1'b1;
                tmr_count_reg <= OSC_COUNT;
                state_reg     <= ST_OSC;
              end else begin
                state_reg <= ST_RUN;
              end
              pdly_req_reg <= 1'b0;
            end
          end
          ST_PDLY: begin
            // Oscillator count starts only once the delay has ended
            if (tmr_done) begin
              if (crystal) begin
                tmr_start_reg <= 1'b1;
                tmr_count_reg <= OSC_COUNT;
                state_reg     <= ST_OSC;
              end else begin
                state_reg <= ST_RUN;
              end
            end
          end
          ST_OSC: begin
            if (tmr_done) begin
              state_reg <= ST_RUN;
            end
          end
          default: begin
            state_reg <= ST_HOLD;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // Core reset: held through delays and while the pin is low
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_reset <= 1'b1;
    end else begin
      // Pin release with delays already spent starts at once
      o_core_reset <= ~master_clear_pin_n_s | (state_reg == ST_HOLD) |
                      (state_reg == ST_PDLY) | (state_reg == ST_OSC);
    end
  end

  // Init values are constant; the strobe tells the core when to load them
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_option_init  <= INIT_OPTION;
      o_portdir_init <= INIT_PORTDIR;
    end else begin
      o_option_init  <= INIT_OPTION;
      o_portdir_init <= INIT_PORTDIR;
    end
  end

  // ***************************************************************
  // Power status register
  // ***************************************************************
  // Hardware clear beats a software write in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_status_reg <= PWR_STATUS_RST;
    end else begin
      if (i_bus.wr && i_bus.addr == ADDR_POWER_RESET_STATUS) begin
        pwr_status_reg <= i_bus.wdata[1:0];
      end
      if (brownout_ev && state_reg != ST_HOLD) begin
        pwr_status_reg[BROWNOUT_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Event status, clear and enable; interrupt output
  // ***************************************************************
  assign evt_set[EVT_BROWNOUT]     = brownout_ev && state_reg != ST_HOLD;
  assign evt_set[EVT_WATCHDOG]     = watchdog_rise;
  assign evt_set[EVT_WAKE]         = (state_reg == ST_SLEEP) && irq_pending;
  assign evt_set[EVT_MASTER_CLEAR] = master_clear_pin_fall;
  assign evt_clr = (i_bus.wr && i_bus.addr == ADDR_EVT_CLEAR) ?
                   i_bus.wdata[EVT_W-1:0] : '0;

  // Set wins over clear so no event is lost
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_status_reg <= '0;
    end else begin
      evt_status_reg <= (evt_status_reg & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_enable_reg <= '0;
    end else if (i_bus.wr && i_bus.addr == ADDR_EVT_ENABLE) begin
      evt_enable_reg <= i_bus.wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evt_status_reg & evt_enable_reg);
    end
  end

  // ***************************************************************
  // Read data, one cycle after the strobe; unmapped reads zero
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= '0;
      if (i_bus.rd) begin
        case (i_bus.addr)
          ADDR_POWER_RESET_STATUS: o_rd_data[1:0] <= pwr_status_reg;
          ADDR_RESET_FLAGS: begin
            o_rd_data[TIMEOUT_FLAG_BIT]   <= o_timeout_flag;
            o_rd_data[POWERDOWN_FLAG_BIT] <= o_powerdown_flag;
            o_rd_data[DATA_W-1:STATE_FIELD_LSB] <= state_reg;
          end
          ADDR_EVT_STATUS: o_rd_data[EVT_W-1:0] <= evt_status_reg;
          ADDR_EVT_ENABLE: o_rd_data[EVT_W-1:0] <= evt_enable_reg;
          default:         o_rd_data <= '0;
        endcase
      end
    end
  end

endmodule // rci_top
`default_nettype wire

// >>> tb/rci_top_properties.sv
// Concurrent checks on the reset-cause and init block ports
`timescale 1ns/1ps
`default_nettype none
module rci_top_properties
  import rci_pkg::*;
#(parameter int unsigned POWERUP_DLY_CYC = 20)(
  // Clock, reset and bus
  input wire logic                     i_sys_clk,
  input wire logic                     i_rst_n,
  input wire rci_pkg::rci_bus_req_s    i_bus,
  input wire rci_pkg::rci_cfg_s        i_cfg,
  input wire logic [rci_pkg::DATA_W-1:0] o_rd_data,
  // Core side results
  input wire logic                     o_core_reset,
  input wire logic                     o_init_strobe,
  input wire logic                     o_pc_load,
  input wire logic [rci_pkg::PC_W-1:0] o_pc_value,
  input wire logic                     o_timeout_flag,
  input wire logic                     o_powerdown_flag,
  input wire logic [rci_pkg::DATA_W-1:0] o_option_init,
  input wire logic [rci_pkg::DATA_W-1:0] o_portdir_init
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] hold_cnt; // Cycles of core reset so far
  logic        por_seq;  // Only the first release is timed, pin resets may be short
  logic [31:0] min_dly;
  // Least hold for the configured start-up
  assign min_dly = (i_cfg.osc_mode != OSC_RC_MODE ? 32'(OSC_START_CYC) : 32'h0) +
    (i_cfg.powerup_delay_enable_n && !i_cfg.brownout_detect_enable ? 32'h0 :
     32'(POWERUP_DLY_CYC));
  // Hold length counter
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_cnt <= '0;
      por_seq  <= 1'b1;
    end else begin
      hold_cnt <= o_core_reset ? hold_cnt + 32'h1 : 32'h0;
      if (!o_core_reset) por_seq <= 1'b0;
    end
  end
  sequence stat_read;
    i_bus.rd && i_bus.addr == ADDR_POWER_RESET_STATUS;
  endsequence
  sequence wake_load;
    o_pc_load && !o_init_strobe;
  endsequence
  a_stat_width: assert property (stat_read |=> o_rd_data[7:2] == 6'h00)
    else $error("upper status bits not zero");
  a_rd_source: assert property (o_rd_data != 8'h00 |-> $past(i_bus.rd))
    else $error("read data without read");
  a_init_vals: assert property (o_option_init == 8'hff && o_portdir_init == 8'hff)
    else $error("init values wrong");
  a_init_pulse: assert property ($rose(o_init_strobe) |=> !o_init_strobe)
    else $error("init strobe too long");
  a_init_pc: assert property (o_init_strobe |-> o_pc_load && o_pc_value == 13'h000)
    else $error("reset pc not zero");
  a_wake_pd: assert property (wake_load |-> !o_powerdown_flag)
    else $error("wake left powerdown set");
  a_wdt_code: assert property (o_init_strobe && $fell(o_timeout_flag) |-> o_powerdown_flag)
    else $error("illegal reset flag code");
  a_start_dly: assert property ($fell(o_core_reset) && por_seq |-> hold_cnt >= min_dly)
    else $error("start-up hold too short");
endmodule // rci_top_properties
bind rci_top rci_top_properties #(.POWERUP_DLY_CYC(POWERUP_DLY_CYC)) chk_inst (.i_sys_clk,
  .i_rst_n, .i_bus, .i_cfg, .o_rd_data, .o_core_reset, .o_init_strobe, .o_pc_load,
  .o_pc_value, .o_timeout_flag, .o_powerdown_flag, .o_option_init, .o_portdir_init);
`default_nettype wire

// >>> tb/rci_top_test.sv
// Self-checking bench for the reset-cause and init block
`timescale 1ns/1ps
`default_nettype none
module rci_top_test;
  import rci_pkg::*;
  localparam int unsigned PDLY = 20; // Short power-up delay keeps the run brief
  logic             clk, rst_n, master_clear_pin_n, bod, wdt, slp, global_irq_enable, irq;
  logic             core_rst, init_s, pc_ld, to_f, pd_f;
  rci_bus_req_s     bus;
  rci_cfg_s         cfg;
  logic [PC_W-1:0]  pc, pc_val, last_pc;
  logic [IRQ_W-1:0] iflg, ien;
  logic [7:0]       rdat;
  logic [1:0]       ef [4] = '{2'b10, 2'b00, 2'b10, 2'b10};
  logic [12:0]      ep [4] = '{13'h000, 13'h124, 13'h004, 13'h124};
  int               fail_count = 0;
  int               tests_run = 0;
  int               n, inits = 0, m;
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  rci_top #(.POWERUP_DLY_CYC(PDLY)) rci_top_inst (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_bus(bus), .o_rd_data(rdat), .i_cfg(cfg), .i_master_clear_pin_n(master_clear_pin_n),
    .i_brownout_det(bod), .i_watchdog_timeout(wdt), .i_sleep_enter(slp), .i_pc(pc),
    .i_global_irq_enable(global_irq_enable), .i_irq_flags(iflg), .i_irq_enables(ien),
    .o_core_reset(core_rst), .o_init_strobe(init_s), .o_pc_load(pc_ld),
    .o_pc_value(pc_val), .o_timeout_flag(to_f), .o_powerdown_flag(pd_f),
    .o_option_init(), .o_portdir_init(), .o_irq(irq));
  // Record loaded pc and init pulses
  always @(posedge clk) begin
    if (pc_ld) last_pc <= pc_val;
    if (init_s && rst_n) inits++;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One-cycle write on an edge, dropped at the edge that takes it
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask
  // Read data stand for the cycle after the strobe; seen at its closing edge
  task rd(input logic [3:0] a, input logic [7:0] e);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    bus <= '0;
    cyc(1);
    chk(rdat, e);
  endtask
  // Bounded wait for core release, n counts cycles held, at least 8
  task wait_run;
    n = 0;
    while ((core_rst !== 1'b0 || n < 8) && n < 4000) begin
      cyc(1);
      n++;
    end
    if (n >= 4000) begin
      fail_count++;
      end_sim;
    end
  endtask
  initial begin
    rst_n = 0; master_clear_pin_n = 1; bod = 0; wdt = 0; slp = 0; global_irq_enable = 0; bus = '0;
    pc = 13'h123; iflg = '0; ien = '0;
    cfg = '{OSC_CRYSTAL_STD_MODE, 1'b1, 1'b1}; // Detection on, brown-out flag valid
    cyc(4);
    rst_n <= 1;
    wait_run;
    chk(n >= PDLY + OSC_START_CYC, 1);
    chk({to_f, pd_f}, 2'b11);
    chk(last_pc, 13'h000);
    rd(ADDR_POWER_RESET_STATUS, 8'h00);
    rd(ADDR_RESET_FLAGS, 8'h0b);
    rd(4'hf, 8'h00);
    wr(ADDR_POWER_RESET_STATUS, 8'hff);
    rd(ADDR_POWER_RESET_STATUS, 8'h03);
    // Watchdog reset in run, its event enabled, then masked and cleared
    wr(ADDR_EVT_ENABLE, 8'h02);
    last_pc = '1;
    wdt <= 1; cyc(3); wdt <= 0; cyc(8);
    chk({to_f, pd_f}, 2'b01);
    chk(last_pc, 13'h000);
    chk(irq, 1);
    rd(ADDR_EVT_STATUS, 8'h02);
    wr(ADDR_EVT_ENABLE, 8'h00); cyc(2); chk(irq, 0);
    wr(ADDR_EVT_CLEAR, 8'h02); wr(ADDR_EVT_ENABLE, 8'h02); cyc(2); chk(irq, 0);
    rd(ADDR_POWER_RESET_STATUS, 8'h03);
    master_clear_pin_n <= 0; cyc(6); master_clear_pin_n <= 1; wait_run;
    chk({to_f, pd_f}, 2'b01);
    // Sleep, then pin, watchdog, interrupt with and without global enable
    for (int k = 0; k < 4; k++) begin
      slp <= 1; cyc(1); slp <= 0; cyc(4);
      chk({to_f, pd_f}, 2'b10);
      last_pc = '1;
      m = inits;
      if (k == 0) begin master_clear_pin_n <= 0; cyc(6); master_clear_pin_n <= 1; end
      else if (k == 1) begin wdt <= 1; cyc(3); wdt <= 0; end
      else begin global_irq_enable <= (k == 2); iflg <= 24'h000010; ien <= 24'h000010; end
      cyc(1040);
      wait_run;
      chk({to_f, pd_f}, ef[k]);
      chk(last_pc, ep[k]);
      chk(inits - m, k == 0);
      iflg <= '0; ien <= '0; global_irq_enable <= 0;
    end
    bod <= 1; cyc(6); bod <= 0; wait_run;
    chk(n >= PDLY + OSC_START_CYC, 1);
    chk({to_f, pd_f}, 2'b11);
    rd(ADDR_POWER_RESET_STATUS, 8'h02);
    end_sim;
  end
endmodule // rci_top_test
`default_nettype wire
